// file: bench/des_ecb_flow_control_tb.sv
// testbench: bus-driven checks of the ecb cipher core
`timescale 1ns/1ps

module des_ecb_flow_control_tb import dsc_pkg::*;;
    localparam logic [63:0] KEY = 64'h1334_5779_9bbc_dff1; // test key
    localparam logic [63:0] PT = 64'h0123_4567_89ab_cdef; // plaintext
    localparam logic [63:0] CT = 64'h85e8_1354_0f0a_b405; // its ciphertext
    logic CLK, RST, HSEL, HWRITE, HREADYOUT, HRESP, OUTPUT_VALID, drain, full;
    logic [31:0] HADDR, HWDATA, HRDATA;
    logic [1:0] HTRANS;
    logic [2:0] HSIZE;
    logic [63:0] RESULT, got;
    logic [7:0] fill;
    wire logic HREADY = HREADYOUT; // single slave
    int bad_count, comparisons, ticks, cyc;

    dsc_top dut (.CLK, .RST, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE, .HREADY, .HWDATA,
        .HRDATA, .HREADYOUT, .HRESP, .RESULT, .OUTPUT_VALID);
    dsc_capture #(.DEPTH(2)) u_cap (.clk(CLK), .rst(RST), .result(RESULT),
        .output_valid(OUTPUT_VALID), .drain, .got, .fill, .full);

    // ********
    // helpers
    // ********
    task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
        comparisons++;
        if (g !== e) begin
            $display("BAD %s expected %h seen %h", n, e, g);
            bad_count++;
        end
    endtask
    // one ahb-lite single transfer, held until hready
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] r);
        @(posedge CLK);
        HSEL <= 1'h1;
        HADDR <= {20'h0_0000, a};
        HTRANS <= 2'h2;
        HWRITE <= w;
        @(posedge CLK);
        while (HREADYOUT !== 1'h1) @(posedge CLK);
        HSEL <= 1'h0;
        HTRANS <= 2'h0;
        HWDATA <= d;
        @(posedge CLK);
        while (HREADYOUT !== 1'h1) @(posedge CLK);
        r = HRDATA;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'h1, a, d, r);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input string n);
        logic [31:0] r;
        bus(1'h0, a, 32'h0000_0000, r);
        chk(n, {32'h0000_0000, e}, {32'h0000_0000, r});
    endtask
    // cycles until the result flag is seen
    task automatic wait_v();
        cyc = 0;
        do begin
            @(posedge CLK);
            cyc++;
        end while (OUTPUT_VALID !== 1'h1);
    endtask
    task automatic close_out();
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // ********
    // clock, watchdog, sequence
    // ********
    initial begin
        CLK = 1'h0;
        forever #2 CLK = ~CLK;
    end
    always @(posedge CLK) begin
        ticks++;
        if (ticks == 3000) begin
            bad_count++;
            close_out();
        end
    end
    initial begin
        {RST, HSEL, HADDR, HTRANS, HWRITE, HWDATA, drain} = '0;
        RST = 1'h1;
        HSIZE = 3'h2;
        repeat (4) @(posedge CLK);
        RST <= 1'h0;
        @(posedge CLK);
        chk("reset result", 64'h0000_0000_0000_0000, RESULT);
        chk("reset valid", 64'h0, {63'h0, OUTPUT_VALID});
        rd(DSC_OFF_STATUS, DSC_WORD_ZERO, "reset status");
        rd(DSC_OFF_CTRL, DSC_WORD_ZERO, "reset ctrl");
        rd(12'h020, DSC_WORD_ZERO, "unmapped");
        wr(DSC_OFF_KEY_HI, KEY[63:32]);
        wr(DSC_OFF_KEY_LO, KEY[31:0]);
        wr(DSC_OFF_DATA_HI, PT[63:32]);
        wr(DSC_OFF_DATA_LO, PT[31:0]);
        wr(DSC_OFF_CTRL, 32'h0000_0003);
        wait_v();
        chk("first latency", 64'(17), 64'(cyc));
        chk("encrypt", CT, RESULT);
        wait_v();
        chk("stream gap", 64'(16), 64'(cyc));
        // let the capture model take the second result before looking at it
        #1;
        chk("second block", CT, got);
        chk("fifo full", 64'h1, {63'h0, full});
        wr(DSC_OFF_CTRL, 32'h0000_0002);
        repeat (40) @(posedge CLK);
        chk("paused count", 64'h2, {56'h0, fill});
        // paused at round 4 of block three: done, busy and round field
        rd(DSC_OFF_STATUS, 32'h0000_0403, "paused status");
        wr(DSC_OFF_STATUS, 32'h0000_0001);
        rd(DSC_OFF_STATUS, 32'h0000_0402, "done cleared");
        rd(DSC_OFF_CTRL, 32'h0000_0002, "ctrl readback");
        rd(DSC_OFF_KEY_LO, KEY[31:0], "key lo");
        drain <= 1'h1;
        @(posedge CLK);
        drain <= 1'h0;
        rd(DSC_OFF_RES_HI, CT[63:32], "result hi");
        rd(DSC_OFF_RES_LO, CT[31:0], "result lo");
        wr(DSC_OFF_CTRL, 32'h0000_0003);
        wait_v();
        chk("resumed block", CT, RESULT);
        wr(DSC_OFF_CTRL, 32'h0000_0002);
        repeat (40) @(posedge CLK);
        chk("stopped count", 64'h1, {56'h0, fill});
        wr(DSC_OFF_DATA_HI, CT[63:32]);
        wr(DSC_OFF_DATA_LO, CT[31:0]);
        wr(DSC_OFF_CTRL, 32'h0000_0005);
        wait_v();
        chk("abort start", 64'(18), 64'(cyc));
        chk("decrypt", PT, RESULT);
        repeat (5) @(posedge CLK);
        wr(DSC_OFF_DATA_HI, PT[63:32]);
        wr(DSC_OFF_DATA_LO, PT[31:0]);
        wr(DSC_OFF_CTRL, 32'h0000_0007);
        wait_v();
        chk("mid abort start", 64'(18), 64'(cyc));
        chk("fresh encrypt", CT, RESULT);
        wr(DSC_OFF_CTRL, 32'h0000_0000);
        close_out();
    end
endmodule // des_ecb_flow_control_tb

bind dsc_top dsc_top_asserts u_chk (.CLK, .RST, .HSEL, .HADDR, .HTRANS, .HWRITE, .HREADY,
    .HWDATA, .HRDATA, .HREADYOUT, .HRESP, .RESULT, .OUTPUT_VALID);

// file: bench/dsc_capture.sv
// model: capture register on the result side, with a full flag
`timescale 1ns/1ps

module dsc_capture import dsc_pkg::*; #(
    parameter int DEPTH = 2 // entries before full
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [63:0] result,
    input wire logic output_valid,
    input wire logic drain,
    output logic [63:0] got,
    output logic [7:0] fill,
    output logic full
);
    // keep the latest one-cycle result, count entries, empty on drain
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            got <= '0;
            fill <= '0;
        end else if (drain) begin
            fill <= '0;
        end else if (output_valid) begin
            got <= result;
            fill <= fill + 8'h01;
        end
    end
    assign full = fill >= DEPTH;
endmodule // dsc_capture

// file: bench/dsc_top_asserts.sv
// checker: port-level timing rules of the ecb cipher core
`timescale 1ns/1ps

module dsc_top_asserts import dsc_pkg::*; (
    input wire logic CLK,
    input wire logic RST,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic HREADY,
    input wire logic [31:0] HWDATA,
    input wire logic [31:0] HRDATA,
    input wire logic HREADYOUT,
    input wire logic HRESP,
    input wire logic [63:0] RESULT,
    input wire logic OUTPUT_VALID
);
    // ********
    // mirror of control word and round count, fed from bus traffic
    // ********
    logic ap_ctrl_q, ap_ctrl_d; // ctrl write seen in address phase
    logic rd_q, rd_d; // read data phase follows
    logic [11:0] a_q, a_d; // address of that read
    logic en_q, en_d; // mirrored enable
    logic ab_q, ab_d; // mirrored one-cycle abort
    logic [3:0] rnd_q, rnd_d; // mirrored round counter
    logic last_step; // sixteenth enabled edge is due
    logic [31:0] res_hi; // upper result word
    logic take; // address phase accepted
    assign take = HSEL && HTRANS[DSC_HTRANS_ACT] && HREADY;
    assign last_step = en_q && !ab_q && rnd_q == DSC_LAST_ROUND;
    assign res_hi = RESULT[63:32];

    // next values of the mirror
    always_comb begin
        ap_ctrl_d = take && HWRITE && HADDR[11:0] == DSC_OFF_CTRL;
        rd_d = take && !HWRITE;
        a_d = HADDR[11:0];
        en_d = ap_ctrl_q ? HWDATA[DSC_CTRL_EN] : en_q;
        ab_d = ap_ctrl_q && HWDATA[DSC_CTRL_ABORT];
        rnd_d = ab_q ? DSC_FIRST_ROUND : (en_q ? rnd_q + DSC_ROUND_STEP : rnd_q);
    end

    // mirror registers
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            {ap_ctrl_q, rd_q, a_q, en_q, ab_q, rnd_q} <= '0;
        end else begin
            {ap_ctrl_q, rd_q, a_q, en_q, ab_q, rnd_q} <= {ap_ctrl_d, rd_d, a_d, en_d, ab_d, rnd_d};
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    // ********
    // properties
    // ********
    sequence s_abort;
        ab_q;
    endsequence
    sequence s_run8;
        (en_q && !ab_q)[*8];
    endsequence
    property p_valid_rise;
        last_step |=> OUTPUT_VALID;
    endproperty
    property p_valid_cause;
        OUTPUT_VALID |-> $past(last_step);
    endproperty
    property p_valid_one;
        OUTPUT_VALID |=> !OUTPUT_VALID;
    endproperty
    property p_freeze;
        !en_q && !ab_q |=> !OUTPUT_VALID && rnd_q == $past(rnd_q);
    endproperty
    property p_result_hold;
        !OUTPUT_VALID |-> $stable(RESULT);
    endproperty
    property p_abort;
        s_abort |=> !OUTPUT_VALID[*8];
    endproperty
    property p_fresh;
        s_abort ##1 s_run8 ##1 s_run8 |=> OUTPUT_VALID;
    endproperty
    property p_bus_okay;
        HREADYOUT && !HRESP;
    endproperty
    property p_rd_result;
        rd_q && a_q == DSC_OFF_RES_HI |-> HRDATA == $past(res_hi);
    endproperty
    property p_rd_round;
        rd_q && a_q == DSC_OFF_STATUS |-> HRDATA[11:8] == $past(rnd_q);
    endproperty

    a_valid_rise: assert property (p_valid_rise) else $error("valid missing after 16 rounds");
    a_valid_cause: assert property (p_valid_cause) else $error("valid without 16 rounds");
    a_valid_one: assert property (p_valid_one) else $error("valid longer than one cycle");
    a_freeze: assert property (p_freeze) else $error("progress while paused");
    a_result_hold: assert property (p_result_hold) else $error("result moved without valid");
    a_abort: assert property (p_abort) else $error("valid soon after abort");
    a_fresh: assert property (p_fresh) else $error("no result after fresh start");
    a_bus_okay: assert property (p_bus_okay) else $error("bus wait or error");
    a_rd_result: assert property (p_rd_result) else $error("result read mismatch");
    a_rd_round: assert property (p_rd_round) else $error("round field mismatch");
endmodule // dsc_top_asserts

// file: include/dsc_pkg.sv
// package: constants, tables and types for the ecb block cipher core
package dsc_pkg;

    // ************************************************************
    // register map (byte offsets, one aligned word each)
    // ************************************************************
    localparam int DSC_DEC_W = 12;                          // decoded address bits
    localparam logic [11:0] DSC_OFF_KEY_HI = 12'h000;       // key bits 1..32
    localparam logic [11:0] DSC_OFF_KEY_LO = 12'h004;       // key bits 33..64
    localparam logic [11:0] DSC_OFF_DATA_HI = 12'h008;      // block bits 1..32
    localparam logic [11:0] DSC_OFF_DATA_LO = 12'h00c;      // block bits 33..64
    localparam logic [11:0] DSC_OFF_CTRL = 12'h010;         // enable, direction, abort
    localparam logic [11:0] DSC_OFF_STATUS = 12'h014;       // done, busy, round
    localparam logic [11:0] DSC_OFF_RES_HI = 12'h018;       // result bits 1..32
    localparam logic [11:0] DSC_OFF_RES_LO = 12'h01c;       // result bits 33..64

    // ************************************************************
    // field positions and reset values
    // ************************************************************
    localparam int DSC_CTRL_EN = 0;                         // enable bit
    localparam int DSC_CTRL_DIR = 1;                        // 1 encrypt, 0 decrypt
    localparam int DSC_CTRL_ABORT = 2;                      // write 1: one-cycle abort
    localparam int DSC_STAT_DONE = 0;                       // sticky block-done flag
    localparam int DSC_STAT_BUSY = 1;                       // block in progress
    localparam int DSC_STAT_RND_LSB = 8;                    // round counter field
    localparam logic [31:0] DSC_WORD_ZERO = 32'h0000_0000;  // reset / unmapped word
    localparam int DSC_HTRANS_ACT = 1;                      // htrans bit: nonseq or seq

    // ************************************************************
    // iteration constants
    // ************************************************************
    localparam logic [3:0] DSC_FIRST_ROUND = 4'h0;          // round that loads a block
    localparam logic [3:0] DSC_LAST_ROUND = 4'hf;           // sixteenth enabled cycle
    localparam logic [3:0] DSC_ROUND_STEP = 4'h1;           // counter increment
    localparam logic [15:0] DSC_SHIFT1_MASK = 16'h8103;     // rounds with single rotate

    // ************************************************************
    // permutation and substitution tables (1-based bit numbers)
    // ************************************************************
    localparam logic [0:31][7:0] DSC_P = 256'h1007_1415_1d0c_1c11_010f_171a_0512_1f0a_0208_180e_201b_0309_130d_1e06_160b_0419;
    localparam logic [0:55][7:0] DSC_PC1 = 448'h3931_2921_1911_0901_3a32_2a22_1a12_0a02_3b33_2b23_1b13_0b03_3c34_2c24_3f37_2f27_1f17_0f07_3e36_2e26_1e16_0e06_3d35_2d25_1d15_0d05_1c14_0c04;
    localparam logic [0:47][7:0] DSC_PC2 = 384'h0e11_0b18_0105_031c_0f06_150a_1713_0c04_1a08_1007_1b14_0d02_2934_1f25_2f37_1e28_332d_2130_2c31_2738_2235_2e2a_3224_1d20;
    localparam logic [0:7][0:63][3:0] DSC_SBOX = {
        256'he4d1_2fb8_3a6c_5907_0f74_e2d1_a6cb_9538_41e8_d62b_fc97_3a50_fc82_4917_5b3e_a06d,
        256'hf18e_6b34_972d_c05a_3d47_f28e_c01a_69b5_0e7b_a4d1_58c6_932f_d8a1_3f42_b67c_05e9,
        256'ha09e_63f5_1dc7_b428_d709_346a_285e_cbf1_d649_8f30_b12c_5ae7_1ad0_6987_4fe3_b52c,
        256'h7de3_069a_1285_bc4f_d8b5_6f03_472c_1ae9_a690_cb7d_f13e_5284_3f06_a1d8_945b_c72e,
        256'h2c41_7ab6_853f_d0e9_eb2c_47d1_50fa_3986_421b_ad78_f9c5_630e_b8c7_1e2d_6f09_a453,
        256'hc1af_9268_0d34_e75b_af42_7c95_61de_0b38_9ef5_28c3_704a_1db6_432c_95fa_be17_608d,
        256'h4b2e_f08d_3c97_5a61_d0b7_491a_e35c_2f86_14bd_c37e_af68_0592_6bd8_14a7_950f_e23c,
        256'hd284_6fb1_a93e_50c7_1fd8_a374_c56b_0e92_7b41_9ce2_06ad_f358_21e7_4a8d_fc90_356b};

    // initial permutation source bit for output position i (0-based)
    function automatic int dsc_ip_idx(input int i);
        return (i < 32) ? (58 + 2 * (i / 8) - 8 * (i % 8))
                        : (57 + 2 * (i / 8 - 4) - 8 * (i % 8));
    endfunction

    // expansion source bit for output position k (0-based)
    function automatic int dsc_e_idx(input int k);
        return ((4 * (k / 6) + k % 6 + 31) % 32) + 1;
    endfunction

    // ************************************************************
    // carrier types
    // ************************************************************
    typedef struct packed {
        logic [31:0] left;          // left half of the data schedule
        logic [31:0] right;         // right half of the data schedule
    } dsc_half_t;

    typedef struct packed {
        logic enable;               // run / pause
        logic direction_select;     // 1 encrypt, 0 decrypt
    } dsc_ctrl_t;

endpackage

// file: rtl/dsc_round.sv
// module: cipher function of one round (expand, key mix, substitute, permute)
`timescale 1ns/1ps

module dsc_round import dsc_pkg::*; (
    input wire logic [31:0] right,     // right half entering the round
    input wire logic [47:0] subkey,    // round key from the key schedule
    output logic [31:0] mixed          // function output, xored into left
);

    logic [47:0] expanded;             // expanded right half
    logic [31:0] substituted;          // concatenated s-box outputs

    // ************************************************************
    // expansion, one bit per entry
    // ************************************************************
    for (genvar k = 0; k < 48; k++) begin : g_exp
        assign expanded[47 - k] = right[32 - dsc_e_idx(k)];
    end

    // ************************************************************
    // substitution boxes, outer bits pick the row
    // ************************************************************
    for (genvar b = 0; b < 8; b++) begin : g_sbox
        logic [5:0] six;               // key-mixed six bits for this box
        assign six = expanded[47 - 6 * b -: 6] ^ subkey[47 - 6 * b -: 6];
        assign substituted[31 - 4 * b -: 4] = DSC_SBOX[b][{six[5], six[0], six[4:1]}];
    end

    // ************************************************************
    // straight permutation
    // ************************************************************
    for (genvar k = 0; k < 32; k++) begin : g_perm
        assign mixed[31 - k] = substituted[32 - int'(DSC_P[k])];
    end

endmodule // dsc_round

// file: rtl/dsc_top.sv
// module: ecb block cipher core with flow control behind an ahb-lite slave
//
// Summary of operation
// - held enable keeps starting blocks without end
// - low enable freezes progress; high resumes it
// - abort discards key and data schedule state
// - abort one cycle; fresh block starts next cycle
// - each block loaded fresh, no chaining
// - valid pulses one cycle after 16 enabled cycles
// - abort synchronous; reset asynchronous
// - direction one encrypts, zero decrypts
//
// Local design decisions: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps

module dsc_top import dsc_pkg::*; (
    input wire logic CLK,
    input wire logic RST,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic HREADY,
    input wire logic [31:0] HWDATA,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    output logic [63:0] RESULT,
    output logic OUTPUT_VALID
);

    // ************************************************************
    // declarations
    // ************************************************************
    logic addr_phase;                          // accepted address phase
    logic wr_pend_q, wr_pend_d;                // write data phase pending
    logic [11:0] wr_addr_q, wr_addr_d;         // latched write offset
    logic [31:0] hrdata_q, hrdata_d;           // registered read data
    logic [31:0] rd_word;                      // read mux output
    logic [63:0] key_q, key_d;                 // cipher key register
    logic [63:0] data_q, data_d;               // input block register
    dsc_ctrl_t ctrl_q, ctrl_d;                 // enable and direction
    logic sync_abort_q, sync_abort_d;          // one-cycle abort pulse
    logic done_q, done_d;                      // sticky block-done flag
    logic [3:0] round_q, round_d;              // iteration counter
    dsc_half_t half_q, half_d;                 // data schedule
    logic [55:0] cd_q, cd_d;                   // key schedule c and d
    logic dir_q, dir_d;                        // direction latched at load
    logic [63:0] result_q, result_d;           // captured result
    logic valid_q, valid_d;                    // one-cycle output valid
    logic start;                               // this cycle loads a block
    logic dir_use;                             // direction for this round
    logic single;                              // single rotate this round
    logic [63:0] ip_out;                       // permuted input block
    logic [55:0] pc1_out;                      // selected key bits
    dsc_half_t src;                            // round input halves
    logic [55:0] cd_src;                       // key schedule before rotate
    logic [55:0] cd_left;                      // rotated left (encrypt)
    logic [55:0] cd_right;                     // rotated right (decrypt)
    logic [55:0] cd_key;                       // schedule feeding pc2
    logic [47:0] subkey;                       // round key
    logic [31:0] mixed;                        // round function output
    logic [63:0] preout;                       // swapped halves after round
    logic [63:0] fp_out;                       // final permuted result

    // ************************************************************
    // ahb-lite slave: zero wait, always okay
    // ************************************************************
    assign addr_phase = HSEL & HTRANS[DSC_HTRANS_ACT] & HREADY;

    // read mux, unmapped offsets read zero
    always_comb begin
        rd_word = DSC_WORD_ZERO;
        case (HADDR[DSC_DEC_W-1:0])
            DSC_OFF_KEY_HI: rd_word = key_q[63:32];
            DSC_OFF_KEY_LO: rd_word = key_q[31:0];
            DSC_OFF_DATA_HI: rd_word = data_q[63:32];
            DSC_OFF_DATA_LO: rd_word = data_q[31:0];
            DSC_OFF_CTRL: begin
                rd_word[DSC_CTRL_EN] = ctrl_q.enable;
                rd_word[DSC_CTRL_DIR] = ctrl_q.direction_select;
            end
            DSC_OFF_STATUS: begin
                rd_word[DSC_STAT_DONE] = done_q;
                rd_word[DSC_STAT_BUSY] = (round_q != DSC_FIRST_ROUND);
                rd_word[DSC_STAT_RND_LSB +: 4] = round_q;
            end
            DSC_OFF_RES_HI: rd_word = result_q[63:32];
            DSC_OFF_RES_LO: rd_word = result_q[31:0];
            default: rd_word = DSC_WORD_ZERO;
        endcase
    end

    // next values of bus state and software registers
    always_comb begin
        wr_pend_d = addr_phase & HWRITE;
        wr_addr_d = addr_phase ? HADDR[DSC_DEC_W-1:0] : wr_addr_q;
        hrdata_d = (addr_phase & ~HWRITE) ? rd_word : hrdata_q;
        key_d = key_q;
        data_d = data_q;
        ctrl_d = ctrl_q;
        sync_abort_d = 1'b0;
        done_d = done_q;
        if (wr_pend_q) begin
            case (wr_addr_q)
                DSC_OFF_KEY_HI: key_d[63:32] = HWDATA;
                DSC_OFF_KEY_LO: key_d[31:0] = HWDATA;
                DSC_OFF_DATA_HI: data_d[63:32] = HWDATA;
                DSC_OFF_DATA_LO: data_d[31:0] = HWDATA;
                DSC_OFF_CTRL: begin
                    ctrl_d.enable = HWDATA[DSC_CTRL_EN];
                    ctrl_d.direction_select = HWDATA[DSC_CTRL_DIR];
                    sync_abort_d = HWDATA[DSC_CTRL_ABORT];
                end
                DSC_OFF_STATUS: begin
                    if (HWDATA[DSC_STAT_DONE]) begin
                        done_d = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
        // completion set wins over a same-cycle clear
        if (valid_q) begin
            done_d = 1'b1;
        end
    end

    // bus and register flops
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= DSC_OFF_KEY_HI;
            hrdata_q <= DSC_WORD_ZERO;
            key_q <= {DSC_WORD_ZERO, DSC_WORD_ZERO};
            data_q <= {DSC_WORD_ZERO, DSC_WORD_ZERO};
            ctrl_q <= '0;
            sync_abort_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            wr_pend_q <= wr_pend_d;
            wr_addr_q <= wr_addr_d;
            hrdata_q <= hrdata_d;
            key_q <= key_d;
            data_q <= data_d;
            ctrl_q <= ctrl_d;
            sync_abort_q <= sync_abort_d;
            done_q <= done_d;
        end
    end

    // constant handshake outputs, still from flops
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
        end else begin
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
        end
    end

    // ************************************************************
    // datapath: load, key rotate, round function
    // ************************************************************
    assign start = (round_q == DSC_FIRST_ROUND);
    assign dir_use = start ? ctrl_q.direction_select : dir_q;
    assign src = start ? ip_out : half_q;
    assign cd_src = start ? pc1_out : cd_q;
    // encrypt walks the shift table forward, decrypt backward
    assign single = dir_use ? DSC_SHIFT1_MASK[round_q]
                            : DSC_SHIFT1_MASK[DSC_LAST_ROUND - round_q];
    assign cd_left = single ? {cd_src[54:28], cd_src[55], cd_src[26:0], cd_src[27]}
                            : {cd_src[53:28], cd_src[55:54], cd_src[25:0], cd_src[27:26]};
    assign cd_right = single ? {cd_src[28], cd_src[55:29], cd_src[0], cd_src[27:1]}
                             : {cd_src[29:28], cd_src[55:30], cd_src[1:0], cd_src[27:2]};
    // decrypt uses the schedule before rotating right
    assign cd_key = dir_use ? cd_left : cd_src;
    assign preout = {src.left ^ mixed, src.right};

    // initial and final permutations, one bit per entry
    for (genvar i = 0; i < 64; i++) begin : g_ipfp
        assign ip_out[63 - i] = data_q[64 - dsc_ip_idx(i)];
        assign fp_out[64 - dsc_ip_idx(i)] = preout[63 - i];
    end

    // key selections, one bit per entry
    for (genvar k = 0; k < 56; k++) begin : g_pc1
        assign pc1_out[55 - k] = key_q[64 - int'(DSC_PC1[k])];
    end
    for (genvar k = 0; k < 48; k++) begin : g_pc2
        assign subkey[47 - k] = cd_key[56 - int'(DSC_PC2[k])];
    end

    // round function
    dsc_round u_round (
        .right(src.right),
        .subkey(subkey),
        .mixed(mixed)
    );

    // ************************************************************
    // iteration control
    // ************************************************************
    always_comb begin
        round_d = round_q;
        half_d = half_q;
        cd_d = cd_q;
        dir_d = dir_q;
        result_d = result_q;
        valid_d = 1'b0;
        if (sync_abort_q) begin
            // abort wins, schedules wiped, next block from round one
            round_d = DSC_FIRST_ROUND;
            half_d = '0;
            cd_d = '0;
        end else if (ctrl_q.enable) begin
            half_d.left = src.right;
            half_d.right = src.left ^ mixed;
            cd_d = dir_use ? cd_left : cd_right;
            dir_d = dir_use;
            if (round_q == DSC_LAST_ROUND) begin
                // block done; wrap and reload on the next enabled cycle
                result_d = fp_out;
                valid_d = 1'b1;
                round_d = DSC_FIRST_ROUND;
            end else begin
                round_d = round_q + DSC_ROUND_STEP;
            end
        end
        // enable low: everything holds
    end

    // cipher flops
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            round_q <= DSC_FIRST_ROUND;
            half_q <= '0;
            cd_q <= '0;
            dir_q <= 1'b0;
            result_q <= {DSC_WORD_ZERO, DSC_WORD_ZERO};
            valid_q <= 1'b0;
        end else begin
            round_q <= round_d;
            half_q <= half_d;
            cd_q <= cd_d;
            dir_q <= dir_d;
            result_q <= result_d;
            valid_q <= valid_d;
        end
    end

    assign HRDATA = hrdata_q;
    assign RESULT = result_q;
    assign OUTPUT_VALID = valid_q;

endmodule // dsc_top
